// ==== include/priv_irq_defs.svh ====
`ifndef PRIV_IRQ_DEFS_SVH
`define PRIV_IRQ_DEFS_SVH

// vector numbers
`define VEC_RESET        5'h00
`define VEC_MEM_ERR      5'h01
`define VEC_INSTR_ERR    5'h02
`define VEC_FIRST_IRQ    5'h03
// slot size in bytes: two words
`define VEC_SLOT_SHIFT   3
// exception cause codes
`define CAUSE_NONE       8'h00
`define CAUSE_LINK_ACC   8'h01
`define CAUSE_AUX_PRIV   8'h02
`define CAUSE_MEM_ERR    8'h03
// status word fields
`define STW_USER_BIT     7
`define STW_E1_BIT       1
`define STW_E2_BIT       2
`define STW_ACT1_BIT     8
`define STW_ACT2_BIT     9
`define STW_EXC_BIT      10
`define STW_ARITH_CONDITION_BITS_LSB     28
`define STW_ARITH_CONDITION_BITS_MASK    32'hF000_0000
// auxiliary register numbers checked for user access
`define AUX_LOOP_BEGIN   12'h002
`define AUX_LOOP_FINISH  12'h003
`define AUX_PROG_CNT     12'h006
`define AUX_STATUS_WORD  12'h00A
`define AUX_EXT_LOW      12'h600
// reset values and build info fields
`define STW_RESET        32'h0000_0000
`define VBASE_RESET      32'h0000_0000
`define LEVEL_RESET      32'h0000_0002
`define BUILD_VERSION    8'h01
`define BUILD_COUNT_32   2'h1

`endif

// ==== include/priv_irq_pkg.sv ====
package priv_irq_pkg;
   typedef enum logic [1:0] {
      ENTRY_NONE,
      ENTRY_EXC,
      ENTRY_L2,
      ENTRY_L1
   } entry_kind_t;
endpackage

// ==== rtl/privilege_and_interrupt_entry.sv ====
`include "priv_irq_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module privilege_and_interrupt_entry
   import priv_irq_pkg::*;
#(
   parameter int NUM_VEC = 32
) (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   // peripheral lines, asynchronous
   input  wire logic [31:0] irq_lines_i,
   // pipeline side
   input  wire logic        insn_boundary_i,
   input  wire logic [31:0] next_pc_i,
   input  wire logic        link_reg_access_i,
   input  wire logic        aux_access_i,
   input  wire logic [11:0] aux_num_i,
   input  wire logic        ext_user_allow_i,
   input  wire logic        trap_i,
   input  wire logic        mem_error_i,
   input  wire logic        machine_check_i,
   input  wire logic        exc_return_i,
   input  wire logic        irq_return_i,
   input  wire logic        flag_write_i,
   input  wire logic [31:0] flag_value_i,
   input  wire logic        debug_halted_i,
   input  wire logic        debug_stw_write_i,
   input  wire logic [31:0] debug_stw_value_i,
   // control registers as plain ports
   input  wire logic        level_assign_we_i,
   input  wire logic [31:0] level_assign_i,
   input  wire logic        sensitivity_we_i,
   input  wire logic [31:0] sensitivity_i,
   input  wire logic        enable_we_i,
   input  wire logic [31:0] enable_i,
   input  wire logic        vector_base_we_i,
   input  wire logic [31:0] vector_base_i,
   // handler rewrite of the exception saved status, picks the return mode
   input  wire logic        exc_status_we_i,
   input  wire logic [31:0] exc_status_i,
   // outputs
   output logic             user_mode_o,
   output logic [31:0]      machine_status_word_o,
   output logic [31:0]      level1_return_link_o,
   output logic [31:0]      level2_return_link_o,
   output logic [31:0]      level1_saved_status_o,
   output logic [31:0]      level2_saved_status_o,
   output logic [31:0]      exception_return_addr_o,
   output logic [31:0]      exception_saved_status_o,
   output logic [7:0]       exception_cause_reg_o,
   output logic [31:0]      vector_base_o,
   output logic [31:0]      vector_unit_build_info_o,
   output logic [31:0]      pending_o,
   output logic             redirect_o,
   output logic [31:0]      redirect_pc_o,
   output logic [4:0]       redirect_vec_o,
   output logic             access_fault_o
);

   if (NUM_VEC != 32) begin
      $error("only 32 vectors supported");
   end

   // two-flop synchroniser for the asynchronous lines
   logic [31:0] sync1_q;
   logic [31:0] sync2_q;
   logic [31:0] prev_q;
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         sync1_q <= '0;
         sync2_q <= '0;
         prev_q  <= '0;
      end else begin
         sync1_q <= irq_lines_i;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   function automatic logic [31:0] slot_addr(input logic [31:0] base, input logic [4:0] v);
      slot_addr = base + ({27'h000_0000, v} << `VEC_SLOT_SHIFT);
   endfunction

   function automatic logic user_aux_ok(input logic [11:0] n, input logic ext_ok);
      user_aux_ok = (n == `AUX_PROG_CNT) || (n == `AUX_STATUS_WORD) ||
                    (n == `AUX_LOOP_BEGIN) || (n == `AUX_LOOP_FINISH) ||
                    ((n >= `AUX_EXT_LOW) && ext_ok);
   endfunction

   function automatic logic [5:0] first_set(input logic [31:0] m);
      first_set = 6'h20;
      for (int i = 31; i >= 0; i--) begin
         if (m[i]) begin
            first_set = 6'(i); // lowest line wins
         end
      end
   endfunction

   logic [31:0] stw_q;
   logic [31:0] level_q;
   logic [31:0] sense_q;
   logic [31:0] enable_q;
   logic [31:0] pend_q;
   logic [31:0] vbase_q;

   // configuration: level, trigger, enables, base
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         level_q  <= `LEVEL_RESET;
         sense_q  <= '0;
         enable_q <= '0;
         vbase_q  <= `VBASE_RESET;
      end else begin
         if (level_assign_we_i) begin
            level_q <= level_assign_i;
         end
         if (sensitivity_we_i) begin
            sense_q <= sensitivity_i;
         end
         if (enable_we_i) begin
            enable_q <= enable_i; // software gates lines while reprogramming
         end
         if (vector_base_we_i) begin
            vbase_q <= {vector_base_i[31:10], 10'h000};
         end
      end
   end

   // a taken pulse irq clears its latch; new edges win over the clear
   logic [31:0] raw_req;
   logic [31:0] take_mask;
   always_comb begin
      raw_req = (sense_q & pend_q) | (~sense_q & sync2_q);
      raw_req[2:0] = 3'b000;
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         pend_q <= '0;
      end else begin
         pend_q <= (pend_q & ~(take_mask & sense_q)) | (sync2_q & ~prev_q & sense_q);
      end
   end

   // priority resolution
   logic [31:0] cand_l2;
   logic [31:0] cand_l1;
   logic [5:0]  win_l2;
   logic [5:0]  win_l1;
   logic        act1;
   logic        act2;
   logic        in_exc;
   logic        is_user;
   logic        user_fault;
   logic        exc_req;
   entry_kind_t kind;
   logic [4:0]  vec;

   assign act1    = stw_q[`STW_ACT1_BIT];
   assign act2    = stw_q[`STW_ACT2_BIT];
   assign in_exc  = stw_q[`STW_EXC_BIT];
   assign is_user = stw_q[`STW_USER_BIT];

   always_comb begin
      cand_l2 = raw_req & enable_q & level_q;
      cand_l1 = raw_req & enable_q & ~level_q;
      win_l2  = first_set(cand_l2);
      win_l1  = first_set(cand_l1);
      user_fault = is_user && ((link_reg_access_i) ||
                   (aux_access_i && !user_aux_ok(aux_num_i, ext_user_allow_i)));
      exc_req = user_fault || mem_error_i || trap_i || machine_check_i;
      kind = ENTRY_NONE;
      vec  = `VEC_RESET;
      take_mask = '0;
      if (exc_req) begin
         kind = ENTRY_EXC; // exceptions first
         vec  = mem_error_i ? `VEC_MEM_ERR :
                (machine_check_i ? `VEC_RESET : `VEC_INSTR_ERR);
      end else if (insn_boundary_i && !in_exc && !win_l2[5] &&
                   stw_q[`STW_E2_BIT] && !act2) begin
         kind = ENTRY_L2;
         vec  = win_l2[4:0];
         take_mask[win_l2[4:0]] = 1'b1;
      end else if (insn_boundary_i && !in_exc && !win_l1[5] &&
                   stw_q[`STW_E1_BIT] && !act1 && !act2) begin
         kind = ENTRY_L1;
         vec  = win_l1[4:0];
         take_mask[win_l1[4:0]] = 1'b1;
      end
   end

   logic [31:0] l1_link_q;
   logic [31:0] l2_link_q;
   logic [31:0] l1_stat_q;
   logic [31:0] l2_stat_q;
   logic [31:0] exception_return_addr_q;
   logic [31:0] estat_q;
   logic [7:0]  cause_q;

   // save links and status on entry
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         l1_link_q <= '0;
         l2_link_q <= '0;
         l1_stat_q <= '0;
         l2_stat_q <= '0;
         exception_return_addr_q    <= '0;
         estat_q   <= '0;
         cause_q   <= `CAUSE_NONE;
      end else begin
         if (exc_status_we_i) begin
            estat_q <= exc_status_i; // entry below overrides
         end
         case (kind)
            ENTRY_L1: begin
               l1_link_q <= next_pc_i;
               l1_stat_q <= stw_q;
            end
            ENTRY_L2: begin
               l2_link_q <= next_pc_i;
               l2_stat_q <= stw_q;
            end
            ENTRY_EXC: begin
               exception_return_addr_q  <= next_pc_i;
               estat_q <= stw_q;
               if (mem_error_i || (user_fault && !trap_i)) begin
                  l2_link_q <= next_pc_i; // memory errors and user faults share the second pair
                  l2_stat_q <= stw_q;
               end
               if (mem_error_i) begin
                  cause_q <= `CAUSE_MEM_ERR;
               end else if (user_fault && link_reg_access_i) begin
                  cause_q <= `CAUSE_LINK_ACC;
               end else if (user_fault) begin
                  cause_q <= `CAUSE_AUX_PRIV;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // status word: mode, enables, active bits; gprs live elsewhere, untouched
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         stw_q <= `STW_RESET; // kernel from reset
      end else if (debug_halted_i && debug_stw_write_i) begin
         stw_q <= debug_stw_value_i;
         stw_q[`STW_USER_BIT] <= 1'b0;
      end else if (kind == ENTRY_EXC) begin
         stw_q[`STW_USER_BIT] <= 1'b0;
         stw_q[`STW_EXC_BIT]  <= 1'b1;
         stw_q[`STW_E1_BIT]   <= 1'b0;
         stw_q[`STW_E2_BIT]   <= 1'b0;
      end else if (kind == ENTRY_L2) begin
         stw_q[`STW_USER_BIT] <= 1'b0;
         stw_q[`STW_ACT2_BIT] <= 1'b1;
      end else if (kind == ENTRY_L1) begin
         stw_q[`STW_USER_BIT] <= 1'b0;
         stw_q[`STW_ACT1_BIT] <= 1'b1;
      end else if (exc_return_i) begin
         stw_q <= estat_q;
      end else if (irq_return_i && act2) begin
         stw_q <= l2_stat_q; // highest active level first
      end else if (irq_return_i && act1) begin
         stw_q <= l1_stat_q;
      end else if (flag_write_i) begin
         stw_q <= (flag_value_i & ~(32'h1 << `STW_USER_BIT)) |
                  (stw_q & (32'h1 << `STW_USER_BIT));
      end
   end

   // entry redirect and visible state, all registered
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         redirect_o     <= 1'b0;
         redirect_pc_o  <= '0;
         redirect_vec_o <= '0;
         access_fault_o <= 1'b0;
      end else begin
         redirect_o     <= (kind != ENTRY_NONE);
         redirect_pc_o  <= slot_addr(vbase_q, vec);
         redirect_vec_o <= vec;
         access_fault_o <= user_fault;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         user_mode_o              <= 1'b0;
         machine_status_word_o    <= `STW_RESET;
         level1_return_link_o     <= '0;
         level2_return_link_o     <= '0;
         level1_saved_status_o    <= '0;
         level2_saved_status_o    <= '0;
         exception_return_addr_o  <= '0;
         exception_saved_status_o <= '0;
         exception_cause_reg_o    <= `CAUSE_NONE;
         vector_base_o            <= `VBASE_RESET;
         vector_unit_build_info_o <= '0;
         pending_o                <= '0;
      end else begin
         user_mode_o              <= is_user;
         machine_status_word_o    <= stw_q;
         level1_return_link_o     <= l1_link_q;
         level2_return_link_o     <= l2_link_q;
         level1_saved_status_o    <= l1_stat_q;
         level2_saved_status_o    <= l2_stat_q;
         exception_return_addr_o  <= exception_return_addr_q;
         exception_saved_status_o <= estat_q;
         exception_cause_reg_o    <= cause_q;
         vector_base_o            <= vbase_q;
         vector_unit_build_info_o <= {vbase_q[31:10], `BUILD_COUNT_32, `BUILD_VERSION};
         pending_o                <= raw_req;
      end
   end

endmodule

`default_nettype wire

// ==== verif/privilege_and_interrupt_entry_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "priv_irq_defs.svh"

module priv_entry_checker (
   input wire logic        clk_sys_i,
   input wire logic        rst_n_i,
   input wire logic [31:0] next_pc_i,
   input wire logic        trap_i,
   input wire logic        mem_error_i,
   input wire logic        machine_check_i,
   input wire logic        exc_return_i,
   input wire logic        irq_return_i,
   input wire logic        flag_write_i,
   input wire logic        debug_halted_i,
   input wire logic        debug_stw_write_i,
   input wire logic        user_mode_o,
   input wire logic [31:0] machine_status_word_o,
   input wire logic [31:0] level2_return_link_o,
   input wire logic [7:0]  exception_cause_reg_o,
   input wire logic [31:0] vector_base_o,
   input wire logic [31:0] vector_unit_build_info_o,
   input wire logic        redirect_o,
   input wire logic [31:0] redirect_pc_o,
   input wire logic [4:0]  redirect_vec_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   sequence mem_err_s;
      mem_error_i && !machine_check_i && !trap_i;
   endsequence
   sequence any_exc_s;
      trap_i || mem_error_i || machine_check_i;
   endsequence

   a_slot_address: assert property (
      redirect_o |-> redirect_pc_o == vector_base_o + {24'h0, redirect_vec_o, 3'h0})
      else $error("entry address is not base plus eight times vector");
   a_mem_err_vector: assert property (
      mem_err_s |=> redirect_o && redirect_vec_o == `VEC_MEM_ERR)
      else $error("memory error did not enter vector one");
   a_mem_err_save: assert property (
      mem_err_s |=> ##1 level2_return_link_o == $past(next_pc_i, 2)
         && exception_cause_reg_o == `CAUSE_MEM_ERR)
      else $error("memory error link or cause wrong");
   a_exc_kernel: assert property (
      any_exc_s |=> ##1 !user_mode_o)
      else $error("exception left user mode set");
   a_exc_masks_irq: assert property (
      any_exc_s |=> ##1 machine_status_word_o[`STW_EXC_BIT]
         && !machine_status_word_o[`STW_E1_BIT] && !machine_status_word_o[`STW_E2_BIT])
      else $error("exception entry kept interrupts enabled");
   a_flag_keeps_mode: assert property (
      flag_write_i && !user_mode_o && !exc_return_i && !irq_return_i
         && !$past(exc_return_i) && !$past(irq_return_i) |=> ##1 !user_mode_o)
      else $error("flag write changed mode");
   a_debug_kernel: assert property (
      debug_halted_i && debug_stw_write_i |=> ##1 !user_mode_o)
      else $error("debug status write left user mode");
   a_reset_kernel: assert property (
      $rose(rst_n_i) |=> ##1 !user_mode_o && machine_status_word_o == `STW_RESET)
      else $error("reset did not leave kernel mode");
   a_build_info: assert property (
      $past(rst_n_i) && $past(rst_n_i, 2)
         |-> vector_unit_build_info_o[9:0] == {`BUILD_COUNT_32, `BUILD_VERSION})
      else $error("build info field wrong");
   a_base_aligned: assert property (
      vector_base_o[9:0] == 10'h000)
      else $error("vector base low bits not zero");
endmodule

bind privilege_and_interrupt_entry priv_entry_checker u_priv_entry_checker (.*);
`default_nettype wire

// ==== verif/irq_source_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// peripheral side: held lines stay up, fired lines give a single-cycle pulse
module irq_source_model (
   input  wire logic        clk_i,
   input  wire logic [31:0] hold_i,
   input  wire logic [31:0] fire_i,
   output logic [31:0]      lines_o
);
   logic [31:0] fire_q;

   always_ff @(posedge clk_i) begin
      fire_q  <= fire_i;
      lines_o <= hold_i | (fire_i & ~fire_q);
   end
endmodule
`default_nettype wire

// ==== verif/test_privilege_and_interrupt_entry.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_fail++; \
   $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end

module test_privilege_and_interrupt_entry;
   logic        clk_sys_i, rst_n_i, insn_boundary_i, link_reg_access_i, aux_access_i;
   logic        ext_user_allow_i, trap_i, mem_error_i, machine_check_i, exc_return_i;
   logic        irq_return_i, flag_write_i, debug_halted_i, debug_stw_write_i;
   logic        level_assign_we_i, sensitivity_we_i, enable_we_i, vector_base_we_i;
   logic        user_mode_o, redirect_o, access_fault_o, exc_status_we_i;
   logic [4:0]  redirect_vec_o;
   logic [7:0]  exception_cause_reg_o;
   logic [11:0] aux_num_i;
   logic [31:0] irq_lines_i, next_pc_i, flag_value_i, debug_stw_value_i, level_assign_i;
   logic [31:0] sensitivity_i, enable_i, vector_base_i, hold, fire, base;
   logic [31:0] machine_status_word_o, level1_return_link_o, level2_return_link_o;
   logic [31:0] level1_saved_status_o, level2_saved_status_o, exception_return_addr_o;
   logic [31:0] exception_saved_status_o, vector_base_o, vector_unit_build_info_o;
   logic [31:0] pending_o, redirect_pc_o, exc_status_i;
   int          n_fail, check_count;

   privilege_and_interrupt_entry u_privilege_and_interrupt_entry (.*);
   irq_source_model u_irq_source_model (
      .clk_i   (clk_sys_i),
      .hold_i  (hold),
      .fire_i  (fire),
      .lines_o (irq_lines_i)
   );

   initial begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end

   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask

   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // waits for the next entry, then checks slot number and address
   task automatic expect_entry(input logic [4:0] v);
      int i;
      i = 0;
      while (redirect_o !== 1'b1 && i < 12) begin
         tick(1);
         i++;
      end
      if (i == 12) begin
         n_fail++;
         $display("[FAIL] %0t entry never came", $time);
         finish_test();
      end else begin
         `CHK(redirect_vec_o, v)
         `CHK(redirect_pc_o, base + {24'h0, v, 3'h0})
         tick(1);
      end
   endtask

   task automatic no_entry(input int n);
      repeat (n) begin
         tick(1);
         `CHK(redirect_o, 1'b0)
      end
   endtask

   initial begin
      {rst_n_i, link_reg_access_i, aux_access_i, trap_i, mem_error_i} = '0;
      {machine_check_i, exc_return_i, irq_return_i, flag_write_i, debug_stw_write_i} = '0;
      {level_assign_we_i, sensitivity_we_i, enable_we_i, vector_base_we_i, exc_status_we_i} = '0;
      {hold, fire, flag_value_i, debug_stw_value_i, level_assign_i} = '0;
      {sensitivity_i, enable_i, vector_base_i, aux_num_i, base, exc_status_i} = '0;
      insn_boundary_i = 1'b1;
      debug_halted_i = 1'b1;
      ext_user_allow_i = 1'b1;
      next_pc_i = 32'h0000_1000;
      n_fail = 0;
      check_count = 0;
      tick(4);
      rst_n_i = 1'b1;
      tick(3);
      `CHK(user_mode_o, 1'b0)
      `CHK(vector_unit_build_info_o, 32'h0000_0101)
      base = 32'h0001_2400;
      vector_base_i = 32'h0001_27FF;
      pulse(vector_base_we_i);
      tick(3);
      `CHK(vector_base_o, base)
      `CHK(vector_unit_build_info_o, 32'h0001_2501)
      debug_stw_value_i = 32'h0000_0086;
      pulse(debug_stw_write_i);
      tick(2);
      `CHK(user_mode_o, 1'b0)
      flag_value_i = 32'h0000_0086;
      pulse(flag_write_i);
      tick(2);
      `CHK(user_mode_o, 1'b0)
      `CHK(machine_status_word_o[2:1], 2'b11)
      // kernel may touch link and privileged aux registers freely
      aux_num_i = 12'h200;
      link_reg_access_i = 1'b1;
      aux_access_i = 1'b1;
      tick(1);
      link_reg_access_i = 1'b0;
      aux_access_i = 1'b0;
      repeat (3) begin
         `CHK(access_fault_o, 1'b0)
         tick(1);
      end
      `CHK(exception_cause_reg_o, 8'h00)
      pulse(enable_we_i);
      tick(5);
      `CHK(pending_o, 32'h0000_0000)
      level_assign_i = 32'h0000_0200;
      pulse(level_assign_we_i);
      sensitivity_i = 32'h0000_0040;
      pulse(sensitivity_we_i);
      enable_i = 32'h0000_0260;
      pulse(enable_we_i);
      hold = 32'h0000_0020;
      expect_entry(5'd5);
      `CHK(level1_return_link_o, 32'h0000_1000)
      `CHK(level1_saved_status_o[2:1], 2'b11)
      next_pc_i = 32'h0000_2000;
      hold = 32'h0000_0220;
      expect_entry(5'd9);
      `CHK(level2_return_link_o, 32'h0000_2000)
      `CHK(level1_return_link_o, 32'h0000_1000)
      // level 1 stays refused until both active levels have returned
      hold = 32'h0000_0020;
      fire = 32'h0000_0040;
      no_entry(5);
      pulse(irq_return_i);
      no_entry(6);
      pulse(irq_return_i);
      expect_entry(5'd5);
      hold = 32'h0000_0000;
      fire = 32'h0000_0000;
      tick(4);
      pulse(irq_return_i);
      expect_entry(5'd6);
      next_pc_i = 32'h0000_3000;
      hold = 32'h0000_0200;
      pulse(mem_error_i);
      expect_entry(5'd1);
      `CHK(exception_cause_reg_o, 8'h03)
      `CHK(level2_return_link_o, 32'h0000_3000)
      `CHK(machine_status_word_o[10:9], 2'b10)
      `CHK(machine_status_word_o[2:1], 2'b00)
      no_entry(8);
      pulse(trap_i);
      expect_entry(5'd2);
      `CHK(exception_return_addr_o, 32'h0000_3000)
      pulse(machine_check_i);
      expect_entry(5'd0);
      `CHK(user_mode_o, 1'b0)
      // handler rewrites saved status to drop into user mode
      hold = 32'h0000_0000;
      exc_status_i = 32'h0000_0080;
      pulse(exc_status_we_i);
      pulse(exc_return_i);
      tick(1);
      `CHK(user_mode_o, 1'b1)
      `CHK(exception_saved_status_o, 32'h0000_0080)
      next_pc_i = 32'h0000_4000;
      aux_num_i = 12'h006;
      pulse(aux_access_i);
      `CHK(access_fault_o, 1'b0)
      `CHK(redirect_o, 1'b0)
      aux_num_i = 12'h600;
      tick(1);
      pulse(aux_access_i);
      `CHK(access_fault_o, 1'b0)
      ext_user_allow_i = 1'b0;
      tick(1);
      pulse(aux_access_i);
      `CHK(access_fault_o, 1'b1)
      expect_entry(5'd2);
      `CHK(exception_cause_reg_o, 8'h02)
      `CHK(user_mode_o, 1'b0)
      `CHK(level2_return_link_o, 32'h0000_4000)
      `CHK(level2_saved_status_o, 32'h0000_0080)
      pulse(exc_return_i);
      pulse(link_reg_access_i);
      `CHK(access_fault_o, 1'b1)
      expect_entry(5'd2);
      `CHK(exception_cause_reg_o, 8'h01)
      `CHK(user_mode_o, 1'b0)
      finish_test();
   end
endmodule
`default_nettype wire
